// file: hdl/vrs_pkg.sv
// Constants, types and helper functions for the voltage reference sequencer
//------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------
package vrs_pkg;

    //--------------------------------------------------------------------
    // Widths
    //--------------------------------------------------------------------
    localparam int CODE_W  = 8;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int NPH     = 6;
    localparam int CUR_W   = 12;
    localparam int SUM_W   = 15;
    localparam int CNT_W   = 3;
    localparam int GAIN_W  = 8;
    localparam int PROD_W  = SUM_W + GAIN_W;
    localparam int DROOP_W = 19;
    localparam int TMR_W   = 8;
    localparam int PIN_W   = 8;
    localparam int IRQ_W   = 4;
    localparam int CTRL_W  = 3;
    localparam int STAT_W  = 8;
    localparam int CMD_W   = CODE_W + 3;

    //--------------------------------------------------------------------
    // Timing
    //--------------------------------------------------------------------
    localparam int CLK_MHZ        = 20;
    localparam int STEP_UV        = 5000;
    localparam int FAST_SLEW_MVUS = 20;
    localparam int SLOW_SLEW_MVUS = 5;
    localparam int MASK_DLY_NS    = 8000;
    localparam int FAST_STEP_CYC_I = STEP_UV * CLK_MHZ / (FAST_SLEW_MVUS * 1000);
    localparam int SLOW_STEP_CYC_I = STEP_UV * CLK_MHZ / (SLOW_SLEW_MVUS * 1000);
    localparam int MASK_DLY_CYC_I  = (MASK_DLY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [TMR_W-1:0] FAST_STEP_CYC =
        TMR_W'((FAST_STEP_CYC_I < 1) ? 1 : FAST_STEP_CYC_I);
    localparam logic [TMR_W-1:0] SLOW_STEP_CYC =
        TMR_W'((SLOW_STEP_CYC_I < 1) ? 1 : SLOW_STEP_CYC_I);
    localparam logic [TMR_W-1:0] MASK_DLY_CYC  = TMR_W'(MASK_DLY_CYC_I);
    localparam logic [CODE_W-1:0] OFF_CODE     = 8'h00;

    //--------------------------------------------------------------------
    // Register map and fields
    //--------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] A_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] A_CMD     = 8'h04;
    localparam logic [ADDR_W-1:0] A_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] A_MP_REF  = 8'h0C;
    localparam logic [ADDR_W-1:0] A_SP_REF  = 8'h10;
    localparam logic [ADDR_W-1:0] A_GAIN    = 8'h14;
    localparam logic [ADDR_W-1:0] A_IRQ_ST  = 8'h18;
    localparam logic [ADDR_W-1:0] A_IRQ_CLR = 8'h1C;
    localparam logic [ADDR_W-1:0] A_IRQ_EN  = 8'h20;

    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_MEM_BIT   = 1;
    localparam int CTRL_DROOP_BIT = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h5;
    localparam logic [GAIN_W-1:0] GAIN_RST = 8'h10;
    localparam int GAIN_FRAC      = 4;
    localparam int MEM_SHIFT      = 2;

    localparam int IRQ_MP_DONE = 0;
    localparam int IRQ_SP_DONE = 1;
    localparam int IRQ_FAULT   = 2;
    localparam int IRQ_REJECT  = 3;

    //--------------------------------------------------------------------
    // Types
    //--------------------------------------------------------------------
    typedef struct packed {
        logic              slow;
        logic              sel_sp;
        logic              sel_mp;
        logic [CODE_W-1:0] code;
    } vrs_cmd_t;

    typedef struct packed {
        logic ov;
        logic uv;
        logic oc;
    } vrs_prot_t;

    typedef enum logic [3:0] {
        SS_OFF   = 4'b0001,
        SS_HIZ   = 4'b0010,
        SS_RUN   = 4'b0100,
        SS_FAULT = 4'b1000
    } vrs_ss_t;

    //--------------------------------------------------------------------
    // Functions
    //--------------------------------------------------------------------
    function automatic vrs_ss_t vrs_ss_next(vrs_ss_t cur, logic en,
                                            logic off, logic pulse,
                                            logic flt);
        vrs_ss_t nxt;
        nxt = cur;
        case (cur)
            SS_OFF:   nxt = (en && !off) ? SS_HIZ : SS_OFF;
            SS_HIZ:   nxt = (!en || off) ? SS_OFF :
                            (pulse ? SS_RUN : SS_HIZ);
            SS_RUN:   nxt = (!en || off) ? SS_OFF : SS_RUN;
            SS_FAULT: nxt = SS_FAULT;
            default:  nxt = SS_OFF;
        endcase
        if (flt) begin
            nxt = SS_FAULT;
        end
        return nxt;
    endfunction

    function automatic logic [DROOP_W-1:0] vrs_droop(logic [PROD_W-1:0] p,
                                                     logic en, logic mem);
        logic [PROD_W-1:0] s;
        s = mem ? (p >> (GAIN_FRAC + MEM_SHIFT)) : (p >> GAIN_FRAC);
        return en ? s[DROOP_W-1:0] : '0;
    endfunction

endpackage

// file: hdl/vrs_ramp.sv
// Reference ramp generator with protection mask delay for one section
module vrs_ramp (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       srst,
    // Command
    input  wire logic                       load,
    input  wire logic [vrs_pkg::CODE_W-1:0] load_code,
    input  wire logic                       load_slow,
    // State
    output logic      [vrs_pkg::CODE_W-1:0] ref_code,
    output logic      [vrs_pkg::CODE_W-1:0] tgt_code,
    output logic                            active,
    output logic                            mask,
    output logic                            done
);
    import vrs_pkg::*;

    logic [CODE_W-1:0] ref_q;
    logic [CODE_W-1:0] tgt_q;
    logic [TMR_W-1:0]  tmr_q;
    logic [TMR_W-1:0]  dly_q;
    logic              act_q;
    logic              slow_q;

    wire               at_tgt   = (ref_q == tgt_q);
    wire               step_now = act_q && !at_tgt && (tmr_q == '0);
    wire [TMR_W-1:0]   cur_ivl  = slow_q ? SLOW_STEP_CYC : FAST_STEP_CYC;
    wire [TMR_W-1:0]   new_ivl  = load_slow ? SLOW_STEP_CYC
                                            : FAST_STEP_CYC;
    wire [CODE_W-1:0]  ref_up   = ref_q + 8'h01;
    wire [CODE_W-1:0]  ref_dn   = ref_q - 8'h01;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ref_q  <= OFF_CODE;
            tgt_q  <= OFF_CODE;
            tmr_q  <= '0;
            dly_q  <= '0;
            act_q  <= 1'b0;
            slow_q <= 1'b0;
        end else begin
            if (act_q && !at_tgt) begin
                tmr_q <= step_now ? cur_ivl - 8'h01 : tmr_q - 8'h01;
            end
            if (step_now) begin
                ref_q <= (ref_q < tgt_q) ? ref_up : ref_dn;
            end
            if (act_q && at_tgt) begin
                act_q <= 1'b0;
                dly_q <= MASK_DLY_CYC;
            end else if (!act_q && dly_q != '0) begin
                dly_q <= dly_q - 8'h01;
            end
            if (load) begin
                // Retarget keeps the running step timer
                tgt_q  <= load_code;
                slow_q <= load_slow;
                act_q  <= (load_code != ref_q) ||
                          (act_q && !at_tgt);
                if (!act_q || at_tgt) begin
                    tmr_q <= new_ivl - 8'h01;
                end
            end
        end
    end

    assign ref_code = ref_q;
    assign tgt_code = tgt_q;
    assign active   = act_q;
    assign mask     = act_q || (dly_q != '0);
    assign done     = act_q && at_tgt && !load;
endmodule

// file: hdl/vrs_top.sv
// Voltage reference sequencer: ramps, protection masking, soft-start, droop
module vrs_top (
    // Clock and reset
    input  wire logic                                        mclk,
    input  wire logic                                        srst,
    // Register port
    input  wire logic [vrs_pkg::ADDR_W-1:0]                  reg_addr,
    input  wire logic [vrs_pkg::DATA_W-1:0]                  reg_wdata,
    input  wire logic                                        reg_wr,
    input  wire logic                                        reg_rd,
    output logic      [vrs_pkg::DATA_W-1:0]                  reg_rdata,
    // Voltage command port
    input  wire logic                                        cmd_valid,
    input  wire vrs_pkg::vrs_cmd_t                           cmd_in,
    output logic                                             cmd_reject,
    // Protection pins
    input  wire vrs_pkg::vrs_prot_t                          mp_prot_in,
    input  wire vrs_pkg::vrs_prot_t                          sp_prot_in,
    input  wire logic                                        total_oc_in,
    // Modulator requests and current readings
    input  wire logic [vrs_pkg::NPH-1:0]                     pwm_req,
    input  wire logic                                        sp_pwm_req,
    input  wire logic [vrs_pkg::NPH-1:0]                     phase_active,
    input  wire logic [vrs_pkg::NPH-1:0][vrs_pkg::CUR_W-1:0] phase_current,
    input  wire logic [vrs_pkg::CUR_W-1:0]                   sp_current,
    // Phase drive pins
    output logic      [vrs_pkg::NPH-1:0]                     phase_pwm_out,
    output logic      [vrs_pkg::NPH-1:0]                     phase_pwm_oe,
    output logic                                             driver_enable_out,
    // Single-phase pin, two-way
    input  wire logic                                        single_phase_pwm_in,
    output logic                                             single_phase_pwm_out,
    output logic                                             single_phase_pwm_oe,
    // References, current sharing and droop
    output logic      [vrs_pkg::CODE_W-1:0]                  mp_ref_code,
    output logic      [vrs_pkg::CODE_W-1:0]                  sp_ref_code,
    output logic      [vrs_pkg::CUR_W-1:0]                   average_phase_current,
    output logic      [vrs_pkg::NPH-1:0][vrs_pkg::CUR_W:0]   duty_corr,
    output logic      [vrs_pkg::DROOP_W-1:0]                 droop_current_pin,
    output logic      [vrs_pkg::DROOP_W-1:0]                 sp_droop_current_pin,
    // Status
    output logic                                             fault_out,
    output logic                                             irq
);
    import vrs_pkg::*;

    //--------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------
    logic [PIN_W-1:0] s1_q;
    logic [PIN_W-1:0] s2_q;
    logic [PIN_W-1:0] s3_q;
    logic [PIN_W-1:0] pin_q;

    wire [PIN_W-1:0] pin_raw = {single_phase_pwm_in, total_oc_in,
                                sp_prot_in, mp_prot_in};
    // Level changes only once stages two and three agree
    wire [PIN_W-1:0] pin_d = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));

    always_ff @(posedge mclk) begin
        if (srst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            pin_q <= '0;
        end else begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    wire vrs_prot_t mp_prot = vrs_prot_t'(pin_q[2:0]);
    wire vrs_prot_t sp_prot = vrs_prot_t'(pin_q[5:3]);
    wire            tot_oc  = pin_q[6];
    wire            sp_pin  = pin_q[7];

    //--------------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [GAIN_W-1:0] gain_q;
    logic [IRQ_W-1:0]  irq_st_q;
    logic [IRQ_W-1:0]  irq_en_q;
    logic [DATA_W-1:0] rdata_q;
    logic              fault_q;
    logic              sp_dis_q;
    vrs_ss_t           mp_ss_q;
    vrs_ss_t           sp_ss_q;

    wire wr_ctrl = reg_wr && (reg_addr == A_CTRL);
    wire wr_cmd  = reg_wr && (reg_addr == A_CMD);
    wire wr_gain = reg_wr && (reg_addr == A_GAIN);
    wire wr_clr  = reg_wr && (reg_addr == A_IRQ_CLR);
    wire wr_en   = reg_wr && (reg_addr == A_IRQ_EN);
    wire en_bit  = ctrl_q[CTRL_EN_BIT];
    wire mem_bit = ctrl_q[CTRL_MEM_BIT];
    wire drp_bit = ctrl_q[CTRL_DROOP_BIT];

    //--------------------------------------------------------------------
    // Command acceptance
    //--------------------------------------------------------------------
    // Port command wins a same-cycle register command
    wire vrs_cmd_t cmd_sel = cmd_valid ? cmd_in
                                       : vrs_cmd_t'(reg_wdata[CMD_W-1:0]);
    wire cmd_any = cmd_valid || wr_cmd;
    wire take_mp = cmd_any && cmd_sel.sel_mp && !fault_q;
    wire take_sp = cmd_any && cmd_sel.sel_sp && !fault_q && !sp_dis_q;
    assign cmd_reject = cmd_any &&
                        ((cmd_sel.sel_sp && !take_sp) ||
                         (cmd_sel.sel_mp && !take_mp));

    //--------------------------------------------------------------------
    // Reference ramps
    //--------------------------------------------------------------------
    logic [CODE_W-1:0] mp_tgt;
    logic [CODE_W-1:0] sp_tgt;
    logic              mp_act;
    logic              sp_act;
    logic              mp_mask;
    logic              sp_mask;
    logic              mp_done;
    logic              sp_done;

    vrs_ramp u_mp_ramp (
        .mclk      (mclk),
        .srst      (srst),
        .load      (take_mp),
        .load_code (cmd_sel.code),
        .load_slow (cmd_sel.slow),
        .ref_code  (mp_ref_code),
        .tgt_code  (mp_tgt),
        .active    (mp_act),
        .mask      (mp_mask),
        .done      (mp_done)
    );

    vrs_ramp u_sp_ramp (
        .mclk      (mclk),
        .srst      (srst),
        .load      (take_sp),
        .load_code (cmd_sel.code),
        .load_slow (cmd_sel.slow),
        .ref_code  (sp_ref_code),
        .tgt_code  (sp_tgt),
        .active    (sp_act),
        .mask      (sp_mask),
        .done      (sp_done)
    );

    //--------------------------------------------------------------------
    // Protection
    //--------------------------------------------------------------------
    wire mp_trip  = !mp_mask && (mp_prot.ov || mp_prot.uv || mp_prot.oc);
    wire sp_trip  = !sp_mask && !sp_dis_q &&
                    (sp_prot.ov || sp_prot.uv || sp_prot.oc);
    // Total over-current ignores the transition mask
    wire flt_set  = !fault_q && (tot_oc || mp_trip || sp_trip);
    wire flt_now  = fault_q || flt_set;
    // Over-voltage may turn the low side on even while soft-start holds it
    wire mp_ov_ls = !mp_mask && mp_prot.ov && !tot_oc;
    wire sp_ov_ls = !sp_mask && sp_prot.ov && !tot_oc && !sp_dis_q;

    wire mp_off   = (mp_tgt == OFF_CODE) && (mp_ref_code == OFF_CODE);
    wire sp_off   = (sp_tgt == OFF_CODE) && (sp_ref_code == OFF_CODE);
    wire vrs_ss_t mp_ss_d = vrs_ss_next(mp_ss_q, en_bit, mp_off,
                                        |(pwm_req & phase_active), flt_now);
    wire vrs_ss_t sp_ss_d = vrs_ss_next(sp_ss_q, en_bit && !sp_dis_q,
                                        sp_off, sp_pwm_req, flt_now);

    always_ff @(posedge mclk) begin
        if (srst) begin
            fault_q  <= 1'b0;
            sp_dis_q <= 1'b0;
            mp_ss_q  <= SS_OFF;
            sp_ss_q  <= SS_OFF;
        end else begin
            fault_q <= flt_now;
            mp_ss_q <= mp_ss_d;
            sp_ss_q <= sp_ss_d;
            // Pin only sampled while undriven, but pin_q lags the pin, so our own drive can still loop for four cycles after release
            if (!single_phase_pwm_oe) begin
                sp_dis_q <= sp_pin;
            end
        end
    end

    //--------------------------------------------------------------------
    // Drive pins
    //--------------------------------------------------------------------
    wire mp_run = (mp_ss_q == SS_RUN);
    wire sp_run = (sp_ss_q == SS_RUN);

    assign phase_pwm_oe  = (mp_run || mp_ov_ls) ? phase_active
                                                : '0;
    assign phase_pwm_out = mp_run && !mp_ov_ls ? (pwm_req & phase_active)
                                               : '0;
    assign driver_enable_out    = mp_run || mp_ov_ls;
    assign single_phase_pwm_oe  = sp_run || sp_ov_ls;
    assign single_phase_pwm_out = sp_run && !sp_ov_ls && sp_pwm_req;
    assign fault_out            = fault_q;

    //--------------------------------------------------------------------
    // Current sharing and droop
    //--------------------------------------------------------------------
    logic [SUM_W-1:0] cur_sum;
    logic [CNT_W-1:0] act_cnt;
    logic [NPH-1:0][CUR_W:0] corr_d;
    logic [CUR_W-1:0] avg_q;
    logic [NPH-1:0][CUR_W:0] corr_q;
    logic [DROOP_W-1:0] droop_q;
    logic [DROOP_W-1:0] sp_droop_q;

    always_comb begin
        cur_sum = '0;
        act_cnt = '0;
        for (int i = 0; i < NPH; i++) begin
            if (phase_active[i]) begin
                cur_sum = cur_sum + SUM_W'(phase_current[i]);
                act_cnt = act_cnt + 3'h1;
            end
        end
    end

    wire [SUM_W-1:0] avg_w  = (act_cnt == '0) ? '0
                              : cur_sum / SUM_W'(act_cnt);
    wire [CUR_W-1:0] avg_n  = avg_w[CUR_W-1:0];
    wire [PROD_W-1:0] mp_prod = cur_sum * gain_q;
    wire [PROD_W-1:0] sp_prod = PROD_W'(sp_current) * PROD_W'(gain_q);

    always_comb begin
        for (int i = 0; i < NPH; i++) begin
            corr_d[i] = phase_active[i]
                      ? ({1'b0, phase_current[i]} - {1'b0, avg_n})
                      : '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            avg_q      <= '0;
            corr_q     <= '0;
            droop_q    <= '0;
            sp_droop_q <= '0;
        end else begin
            avg_q      <= avg_n;
            corr_q     <= corr_d;
            droop_q    <= vrs_droop(mp_prod, drp_bit, mem_bit);
            sp_droop_q <= vrs_droop(sp_prod, drp_bit && !sp_dis_q,
                                    mem_bit);
        end
    end

    assign average_phase_current = avg_q;
    assign duty_corr             = corr_q;
    assign droop_current_pin     = droop_q;
    assign sp_droop_current_pin  = sp_droop_q;

    //--------------------------------------------------------------------
    // Software registers and interrupt
    //--------------------------------------------------------------------
    wire [IRQ_W-1:0] irq_ev;
    assign irq_ev[IRQ_MP_DONE] = mp_done;
    assign irq_ev[IRQ_SP_DONE] = sp_done;
    assign irq_ev[IRQ_FAULT]   = flt_set;
    assign irq_ev[IRQ_REJECT]  = cmd_reject;

    wire [IRQ_W-1:0] clr_bits = wr_clr ? reg_wdata[IRQ_W-1:0] : '0;
    // A new event outranks a same-cycle clear
    wire [IRQ_W-1:0] irq_st_d = (irq_st_q & ~clr_bits) | irq_ev;

    wire [STAT_W-1:0] stat_w = {sp_run, mp_run, sp_dis_q, fault_q,
                                sp_mask, mp_mask, sp_act, mp_act};

    wire [DATA_W-1:0] rd_mux =
        (reg_addr == A_CTRL)   ? DATA_W'(ctrl_q)      :
        (reg_addr == A_STATUS) ? DATA_W'(stat_w)      :
        (reg_addr == A_MP_REF) ? DATA_W'(mp_ref_code) :
        (reg_addr == A_SP_REF) ? DATA_W'(sp_ref_code) :
        (reg_addr == A_GAIN)   ? DATA_W'(gain_q)      :
        (reg_addr == A_IRQ_ST) ? DATA_W'(irq_st_q)    :
        (reg_addr == A_IRQ_EN) ? DATA_W'(irq_en_q)    : '0;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_q   <= CTRL_RST;
            gain_q   <= GAIN_RST;
            irq_st_q <= '0;
            irq_en_q <= '0;
            rdata_q  <= '0;
        end else begin
            irq_st_q <= irq_st_d;
            rdata_q  <= reg_rd ? rd_mux : '0;
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[CTRL_W-1:0];
            end
            if (wr_gain) begin
                gain_q <= reg_wdata[GAIN_W-1:0];
            end
            if (wr_en) begin
                irq_en_q <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = |(irq_st_q & irq_en_q);
endmodule

// file: tb/vrs_top_assertions.sv
// Port checks for the voltage reference sequencer
module vrs_chk import vrs_pkg::*; (
    input wire logic mclk, srst, reg_rd, reg_wr, cmd_valid,
    input wire logic cmd_reject, total_oc_in, fault_out,
    input wire logic driver_enable_out,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [NPH-1:0] phase_pwm_oe, phase_active,
    input wire logic [CODE_W-1:0] mp_ref_code
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_step; $changed(mp_ref_code); endsequence
    property p_rd; !$past(reg_rd) |-> reg_rdata == '0; endproperty
    a_rd: assert property (p_rd) else $error("stray read data");
    property p_rej; cmd_reject |-> cmd_valid || reg_wr; endproperty
    a_rej: assert property (p_rej) else $error("stray reject");
    property p_oc; total_oc_in |-> ##[1:8] fault_out; endproperty
    a_oc: assert property (p_oc) else $error("no latch");
    property p_hold; fault_out |=> fault_out; endproperty
    a_hold: assert property (p_hold) else $error("fault lost");
    property p_hiz; !driver_enable_out |-> phase_pwm_oe == '0; endproperty
    a_hiz: assert property (p_hiz) else $error("pwm driven");
    property p_run;
        driver_enable_out && !fault_out |-> phase_pwm_oe == phase_active;
    endproperty
    a_run: assert property (p_run) else $error("pwm not driven");
    property p_step;
        s_step |-> mp_ref_code == $past(mp_ref_code) + 8'h01 ||
                   $past(mp_ref_code) == mp_ref_code + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("ref jump");
    property p_gap; s_step |=> $stable(mp_ref_code)[*4]; endproperty
    a_gap: assert property (p_gap) else $error("ref too fast");
endmodule

// file: tb/vrs_board.sv
// Board model of the single-phase pin: strap pull-up or weak pull-down
module vrs_board (
    input  wire logic pull_hi, oe, dout,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Strap wins only while the device lets go of the pin
    assign pin = oe ? dout : pull_hi;
endmodule

// file: tb/vrs_top_bench.sv
// Self-checking bench for the voltage reference sequencer
module vrs_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import vrs_pkg::*;
    typedef struct {logic [5:0] act; int a, b; logic mem;} vrs_row_t;
    vrs_row_t rows[3] = '{'{6'h3F, 12, 6, 0}, '{6'h07, 9, 3, 1},
                          '{6'h0F, 256, 64, 0}};
    logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, cmd_valid = 0;
    logic total_oc_in = 0, sp_pwm_req = 0, pull_hi = 0, sp_pin, rj;
    logic cmd_reject, driver_enable_out, fault_out, irq;
    logic single_phase_pwm_out, single_phase_pwm_oe;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    vrs_cmd_t cmd_in = '0;
    logic [NPH-1:0] pwm_req = '0, phase_active = '1, phase_pwm_oe;
    logic [NPH-1:0][CUR_W-1:0] phase_current = '0;
    logic [NPH-1:0][CUR_W:0] duty_corr;
    logic [CUR_W-1:0] average_phase_current;
    logic [CODE_W-1:0] mp_ref_code;
    logic [DROOP_W-1:0] droop_current_pin;
    int bad_count = 0, checked = 0, cyc = 0, n, s, t;
    vrs_top u_dut (.*, .mp_prot_in('0), .sp_prot_in('0), .sp_current('0),
        .phase_pwm_out(), .single_phase_pwm_in(sp_pin), .sp_ref_code(),
        .sp_droop_current_pin());
    vrs_board u_board (.pull_hi(pull_hi), .oe(single_phase_pwm_oe),
        .dout(single_phase_pwm_out), .pin(sp_pin));
    always #25 mclk = ~mclk;
    task chk(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input int d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge mclk);
        reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a, input int e);
        @(posedge mclk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk);
        reg_rd <= 0;
        #1 chk(reg_rdata, e);
    endtask
    task cmd(input vrs_cmd_t c);
        @(posedge mclk);
        {cmd_in, cmd_valid} <= {c, 1'b1};
        #1 rj = cmd_reject;
        @(posedge mclk);
        cmd_valid <= 0;
    endtask
    // Cycles until the multi-phase reference shows code c
    task wref(input logic [7:0] c);
        for (t = 0; mp_ref_code !== c && t < 300; t++) @(negedge mclk);
    endtask
    task results;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge mclk) if (++cyc == 4000) begin
        bad_count++;
        results;
    end
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 0;
        rd(A_CTRL, CTRL_RST);
        rd(A_GAIN, GAIN_RST);
        rd(8'h3C, 0);
        foreach (rows[i]) begin
            n = $countones(rows[i].act);
            s = rows[i].a + (n - 1) * rows[i].b;
            @(posedge mclk);
            phase_active <= rows[i].act;
            for (int p = 0; p < NPH; p++) phase_current[p] <=
                CUR_W'(rows[i].act[p] ? (p ? rows[i].b : rows[i].a) : 0);
            wr(A_CTRL, rows[i].mem ? 7 : 5);
            repeat (8) @(negedge mclk);
            chk(average_phase_current, s / n);
            chk(duty_corr[0], rows[i].a - s / n);
            chk(droop_current_pin, rows[i].mem ? s / 4 : s);
        end
        wr(A_IRQ_EN, 1);
        cmd('{1'b0, 1'b0, 1'b1, 8'h04});
        wref(1);
        chk({driver_enable_out, phase_pwm_oe}, 0);
        wref(2);
        chk(t, FAST_STEP_CYC);
        rd(A_STATUS, 8'h05);
        cmd('{1'b1, 1'b0, 1'b1, 8'h06});
        wref(3);
        wref(4);
        chk(t, SLOW_STEP_CYC);
        wref(6);
        rd(A_STATUS, 8'h04);
        chk(irq, 1);
        pwm_req <= 6'h01;
        repeat (2) @(negedge mclk);
        chk({driver_enable_out, phase_pwm_oe}, {1'b1, phase_active});
        wr(A_IRQ_CLR, 1);
        repeat (MASK_DLY_CYC) @(negedge mclk);
        chk(irq, 0);
        rd(A_STATUS, 8'h40);
        // Register path command: fast step down to code 5 from idle
        wr(A_CMD, 32'h105);
        wref(5);
        chk(t, FAST_STEP_CYC + 1);
        chk(mp_ref_code, 8'h05);
        pull_hi <= 1;
        repeat (6) @(posedge mclk);
        cmd('{1'b0, 1'b1, 1'b0, 8'h04});
        chk(rj, 1);
        total_oc_in <= 1;
        repeat (8) @(negedge mclk);
        chk({fault_out, driver_enable_out, phase_pwm_oe}, 8'h80);
        cmd('{1'b0, 1'b0, 1'b1, 8'h02});
        chk(rj, 1);
        rd(A_IRQ_ST, 8'h0D);
        results;
    end
endmodule
bind vrs_top vrs_chk u_chk (.*);
